// ---- icdar_pkg.sv ----
// Purpose: Shared constants and types for the two-wire serial bus interface
// Assumes: 8-bit register port at byte offsets, 20 MHz system clock
// Notes:   Pins are open drain; enables are active low
package icdar_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CONTROL    = 8'h18;
  localparam logic [7:0] OFS_STATUS_ONE = 8'h19;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h1A;
  localparam logic [7:0] OFS_SPEED      = 8'h1B;
  localparam logic [7:0] OFS_OWN_LOW    = 8'h1C;
  localparam logic [7:0] OFS_OWN_HIGH   = 8'h1D;
  localparam logic [7:0] OFS_BYTE       = 8'h1E;
  localparam logic [7:0] OFS_EV_FLAGS   = 8'h1F;
  localparam logic [7:0] OFS_EV_MASK    = 8'h20;

  // bus_control fields
  localparam int CTL_PE    = 5;
  localparam int CTL_ENGC  = 4;
  localparam int CTL_START = 3;
  localparam int CTL_ACK   = 2;
  localparam int CTL_STOP  = 1;
  localparam int CTL_ITE   = 0;
  localparam int CTL_W     = 6;

  // scl_speed_control and own_address_high_freq fields
  localparam int SPD_FAST   = 7;
  localparam int OAH_FR_LSB = 6;
  localparam int OAH_AD_LSB = 1;

  // Reset values and codes
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [1:0] FR_RESET        = 2'h1;
  localparam logic [1:0] FR_BELOW_6MHZ   = 2'h0;
  localparam logic [1:0] FR_6_TO_8MHZ    = 2'h1;
  localparam logic [7:0] OWN_LOW_INVALID = 8'h01;
  localparam logic [4:0] TEN_HEADER      = 5'h1E;
  localparam logic [7:0] GENERAL_CALL    = 8'h00;
  localparam logic [8:0] SCL_HALF_MIN    = 9'h003;

  // Event flag bits
  localparam int EV_BYTE = 0;
  localparam int EV_ADDR = 1;
  localparam int EV_STOP = 2;
  localparam int EV_NACK = 3;
  localparam int EV_ARB  = 4;
  localparam int EV_BERR = 5;
  localparam int EV_W    = 6;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_ADDR   = 9'h002,
    ST_ADDR2  = 9'h004,
    ST_ACK    = 9'h008,
    ST_RX     = 9'h010,
    ST_TX     = 9'h020,
    ST_HOLD   = 9'h040,
    ST_MSTART = 9'h080,
    ST_MSTOP  = 9'h100
  } icdar_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } icdar_bus_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } icdar_line_s;

  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [7:0]       speed;
    logic [7:0]       own_low;
    logic [1:0]       fr;
    logic [1:0]       add98;
    logic [7:0]       data_byte;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  mask;
    logic             tra, busy, btf, adsl, master, sb, add10;
    logic             af, stopf, arlo, berr, gcal;
    logic             buf_full, sda_low, scl_low, gen_high, ack_drv;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    icdar_state_e     state;
    icdar_state_e     post;
    logic [7:0]       rdata;
  } icdar_core_s;
endpackage

// ---- icdar_scl_gen.sv ----
// Purpose: Half-period strobe for the generated serial clock
// Assumes: divider and mode held stable while running
// Notes:   Standard mode doubles the half period of fast mode
`timescale 1ns/100ps
module icdar_scl_gen #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             run,
  input  wire logic             fast,
  input  wire logic [DIV_W-1:0] divider,
  // Strobe
  output logic                  tick
);
  import icdar_pkg::*;

  logic [DIV_W+1:0] count;
  logic [DIV_W+1:0] next_count;
  logic [DIV_W+1:0] half;

  always_comb begin
    half = fast ? {2'b00, divider} : {1'b0, divider, 1'b0};
    // Tiny dividers would outrun the pin synchronisers
    if (half < (DIV_W+2)'(SCL_HALF_MIN)) begin
      half = (DIV_W+2)'(SCL_HALF_MIN);
    end
    tick = run && (count == half);
    next_count = (!run || tick) ? '0 : count + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ---- icdar_addr_match.sv ----
// Purpose: Compares a received address byte with the own address
// Assumes: rx_byte holds the complete byte, direction bit in bit 0
// Notes:   Purely combinational
`timescale 1ns/100ps
module icdar_addr_match (
  // Own address
  input  wire logic [7:0] own_low,
  input  wire logic [1:0] add98,
  input  wire logic       gc_en,
  // Received byte
  input  wire logic [7:0] rx_byte,
  // Results
  output logic            hit7,
  output logic            hit_hdr,
  output logic            hit_low,
  output logic            gcall
);
  import icdar_pkg::*;

  always_comb begin
    // Bit 0 is don't care, so either direction matches
    hit7 = (rx_byte[7:1] == own_low[7:1]) && (rx_byte[7:3] != TEN_HEADER)
           && (own_low != OWN_LOW_INVALID);
    hit_hdr = (rx_byte[7:3] == TEN_HEADER) && (rx_byte[2:1] == add98);
    hit_low = (rx_byte == own_low);
    gcall = gc_en && (rx_byte == GENERAL_CALL);
  end
endmodule

// ---- icdar_core.sv ----
// Purpose: Register file and byte engine of the two-wire bus interface
// Assumes: Register strobes are one cycle; pins arrive asynchronously
// Notes:   Master mode transmits only; slave mode receives and transmits
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module icdar_core (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Register port
  input  wire icdar_pkg::icdar_bus_s  bus,
  output logic [7:0]                  rdata,
  // Bus lines, open drain
  input  wire icdar_pkg::icdar_line_s line_i,
  output icdar_pkg::icdar_line_s      line_o,
  output icdar_pkg::icdar_line_s      line_oe_b,
  // Interrupt
  output logic                        irq
);
  import icdar_pkg::*;

  localparam icdar_core_s CORE_RESET = '{state: ST_IDLE, post: ST_IDLE,
                                         fr: FR_RESET, default: '0};

  icdar_line_s     meta;
  icdar_line_s     sync;
  icdar_line_s     last;
  icdar_core_s     c;
  icdar_core_s     n;
  logic            scl_rise, scl_fall, start_det, stop_det;
  logic            gen_run, tick;
  logic            hit7, hit_hdr, hit_low, gcall;
  logic            mid, byte_end;
  logic [7:0]      s1, s2;
  logic [EV_W-1:0] ev_set;

  // Lines idle high, so the synchronisers reset high
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta <= '1;
      sync <= '1;
      last <= '1;
    end else begin
      meta <= line_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign scl_rise  = sync.scl & ~last.scl;
  assign scl_fall  = ~sync.scl & last.scl;
  assign start_det = sync.scl & last.scl & last.sda & ~sync.sda;
  assign stop_det  = sync.scl & last.scl & ~last.sda & sync.sda;
  assign gen_run   = (c.master || c.state == ST_MSTART) && !c.scl_low;

  icdar_scl_gen #(
    .DIV_W (7)
  ) u_gen (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (gen_run),
    .fast    (c.speed[SPD_FAST]),
    .divider (c.speed[6:0]),
    .tick    (tick)
  );

  icdar_addr_match u_match (
    .own_low (c.own_low),
    .add98   (c.add98),
    .gc_en   (c.ctl[CTL_ENGC]),
    .rx_byte (c.shreg),
    .hit7    (hit7),
    .hit_hdr (hit_hdr),
    .hit_low (hit_low),
    .gcall   (gcall)
  );

  always_comb begin
    n = c;
    ev_set = '0;
    s1 = {c.btf | c.adsl | c.sb | c.af | c.stopf | c.arlo | c.berr,
          c.add10, c.tra, c.busy, c.btf, c.adsl, c.master, c.sb};
    s2 = {3'b000, c.af, c.stopf, c.arlo, c.berr, c.gcal};
    // A proper stop or repeated start comes after one clock rise of the next byte
    mid = (c.bitcnt > 4'h1) && (c.state inside {ST_ADDR, ST_ADDR2, ST_RX, ST_TX});
    byte_end = scl_fall && (c.bitcnt == 4'h8);

    // Register reads; data stands for one cycle only
    n.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        OFS_CONTROL:    n.rdata = {2'b00, c.ctl};
        OFS_STATUS_ONE: n.rdata = s1;
        OFS_STATUS_TWO: begin
          n.rdata = s2;
          n.af = 1'b0;
          n.stopf = 1'b0;
          n.arlo = 1'b0;
          n.berr = 1'b0;
        end
        OFS_SPEED:      n.rdata = c.speed;
        OFS_OWN_LOW:    n.rdata = c.own_low;
        OFS_OWN_HIGH:   n.rdata = {c.fr, 3'b000, c.add98, 1'b0};
        OFS_BYTE: begin
          n.rdata = c.data_byte;
          n.btf = 1'b0;
          if (!c.tra) begin
            n.buf_full = 1'b0;
          end
        end
        OFS_EV_FLAGS:   n.rdata = {2'b00, c.ev};
        OFS_EV_MASK:    n.rdata = {2'b00, c.mask};
        default:        n.rdata = '0;
      endcase
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        OFS_CONTROL:  n.ctl = bus.wdata[CTL_W-1:0];
        OFS_SPEED:    n.speed = bus.wdata;
        OFS_OWN_LOW:  n.own_low = bus.wdata;
        OFS_OWN_HIGH: begin
          n.fr = bus.wdata[OAH_FR_LSB +: 2];
          n.add98 = bus.wdata[OAH_AD_LSB +: 2];
        end
        OFS_BYTE: begin
          n.data_byte = bus.wdata;
          n.buf_full = 1'b1;
          n.btf = 1'b0;
          n.sb = 1'b0;
        end
        OFS_EV_FLAGS: n.ev = c.ev & ~bus.wdata[EV_W-1:0];
        OFS_EV_MASK:  n.mask = bus.wdata[EV_W-1:0];
        default:      ;
      endcase
    end

    // Generated clock toggles each half period while mastering
    if (tick && c.master && c.state != ST_MSTOP) begin
      n.gen_high = ~c.gen_high;
    end
    if (scl_rise && (c.state inside {ST_ADDR, ST_ADDR2, ST_RX, ST_TX})) begin
      n.shreg = {c.shreg[6:0], sync.sda};
      n.bitcnt = c.bitcnt + 4'h1;
    end

    // Freshly written enable counts, so a disable frees lines and status flags at once
    if (!n.ctl[CTL_PE]) begin
      // Configuration fields are left as they are
      n.state = ST_IDLE;
      {n.sda_low, n.scl_low, n.master, n.busy, n.tra, n.buf_full} = '0;
      {n.af, n.stopf, n.arlo, n.berr, n.gcal} = '0;
      {n.btf, n.adsl, n.sb, n.add10, n.bitcnt} = '0;
    end else if (stop_det && c.state != ST_MSTOP) begin
      n.stopf = c.adsl;
      ev_set[EV_STOP] = c.adsl;
      n.berr = mid;
      ev_set[EV_BERR] = mid;
      n.state = ST_IDLE;
      {n.sda_low, n.scl_low, n.master, n.busy, n.tra} = '0;
      {n.adsl, n.add10, n.gcal, n.bitcnt} = '0;
    end else if (start_det && !c.master && c.state != ST_MSTART) begin
      n.berr = mid;
      ev_set[EV_BERR] = mid;
      n.state = ST_ADDR;
      {n.sda_low, n.scl_low, n.tra, n.bitcnt} = '0;
      n.busy = 1'b1;
    end else begin
      case (c.state)
        ST_IDLE: begin
          if (c.ctl[CTL_START] && !c.busy) begin
            n.sda_low = 1'b1;
            n.state = ST_MSTART;
          end
        end
        ST_MSTART: begin
          if (tick) begin
            {n.master, n.sb, n.busy, n.tra, n.scl_low} = '1;
            n.ctl[CTL_START] = 1'b0;
            n.gen_high = 1'b0;
            n.bitcnt = '0;
            n.state = ST_TX;
          end
        end
        ST_ADDR: begin
          if (byte_end) begin
            n.bitcnt = '0;
            n.state = ST_IDLE;
            if (hit_hdr && !c.shreg[0]) begin
              n.add10 = 1'b1;
              n.post = ST_ADDR2;
              n.state = ST_ACK;
            end else if ((hit_hdr && c.add10) || hit7 || gcall) begin
              n.adsl = 1'b1;
              n.gcal = gcall && !hit7;
              n.tra = c.shreg[0];
              n.post = c.shreg[0] ? ST_TX : ST_RX;
              n.state = ST_ACK;
              ev_set[EV_ADDR] = 1'b1;
            end
            n.sda_low = (n.state == ST_ACK);
            n.ack_drv = 1'b1;
          end
        end
        ST_ADDR2: begin
          if (byte_end) begin
            n.bitcnt = '0;
            n.sda_low = hit_low;
            n.ack_drv = 1'b1;
            n.adsl = hit_low;
            n.post = ST_RX;
            n.state = hit_low ? ST_ACK : ST_IDLE;
            ev_set[EV_ADDR] = hit_low;
          end
        end
        ST_RX: begin
          if (byte_end) begin
            n.bitcnt = '0;
            if (!c.buf_full) begin
              n.data_byte = c.shreg;
              {n.buf_full, n.btf, n.ack_drv} = '1;
              n.sda_low = c.ctl[CTL_ACK];
              n.post = ST_RX;
              n.state = ST_ACK;
              ev_set[EV_BYTE] = 1'b1;
            end else begin
              // Stretch the clock until software empties the buffer
              n.scl_low = 1'b1;
              n.state = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (!c.buf_full) begin
            n.data_byte = c.shreg;
            {n.buf_full, n.btf, n.ack_drv} = '1;
            n.sda_low = c.ctl[CTL_ACK];
            n.scl_low = 1'b0;
            n.post = ST_RX;
            n.state = ST_ACK;
            ev_set[EV_BYTE] = 1'b1;
          end
        end
        ST_TX: begin
          if (c.scl_low && c.bitcnt == 4'h0) begin
            if (c.master && c.ctl[CTL_STOP]) begin
              {n.sda_low, n.gen_high, n.scl_low} = 3'b100;
              n.state = ST_MSTOP;
            end else if (c.buf_full) begin
              n.shreg = c.data_byte;
              n.sda_low = ~c.data_byte[7];
              n.buf_full = 1'b0;
              n.scl_low = 1'b0;
            end
          end else if (scl_rise && c.master && !c.sda_low && !sync.sda) begin
            // Another master pulled the line low while we released it
            n.arlo = 1'b1;
            ev_set[EV_ARB] = 1'b1;
            {n.master, n.sda_low, n.scl_low, n.tra} = '0;
            n.state = ST_IDLE;
          end else if (byte_end) begin
            {n.sda_low, n.ack_drv, n.bitcnt} = '0;
            n.btf = 1'b1;
            ev_set[EV_BYTE] = 1'b1;
            n.post = ST_TX;
            n.state = ST_ACK;
          end else if (scl_fall && c.bitcnt != 4'h0) begin
            n.sda_low = ~c.shreg[7];
          end
        end
        ST_ACK: begin
          if (scl_rise && !c.ack_drv && sync.sda) begin
            n.af = 1'b1;
            ev_set[EV_NACK] = 1'b1;
            // A refused slave transmitter lets go of the bus
            n.post = c.master ? ST_TX : ST_IDLE;
          end
          if (scl_fall) begin
            n.sda_low = 1'b0;
            n.bitcnt = '0;
            n.state = c.post;
            n.scl_low = (c.post == ST_TX);
          end
        end
        ST_MSTOP: begin
          if (tick) begin
            if (!c.gen_high) begin
              n.gen_high = 1'b1;
            end else begin
              {n.sda_low, n.master, n.busy, n.tra} = '0;
              n.ctl[CTL_STOP] = 1'b0;
              n.state = ST_IDLE;
            end
          end
        end
        default: n.state = ST_IDLE;
      endcase
    end

    // Hardware set wins over a software clear in the same cycle
    n.ev = n.ev | ev_set;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      c <= CORE_RESET;
    end else begin
      c <= n;
    end
  end

  assign rdata         = c.rdata;
  assign line_o        = '0;
  assign line_oe_b.scl = ~(c.scl_low | (c.master & ~c.gen_high));
  assign line_oe_b.sda = ~c.sda_low;
  assign irq           = c.ctl[CTL_ITE] & (|(c.ev & c.mask));
endmodule

// ---- icdar_core_monitor.sv ----
// Purpose: Port checks for the two-wire bus interface core
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the core below the module
`timescale 1ns/100ps
module icdar_core_monitor (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  // Register port and pins
  input wire icdar_pkg::icdar_bus_s  bus,
  input wire logic [7:0]             rdata,
  input wire icdar_pkg::icdar_line_s line_oe_b
);
  import icdar_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside reply");
  AST_UNMAPPED: assert property (
    bus.rd && (bus.addr < 8'h18 || bus.addr > 8'h20) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTL: assert property (
    bus.wr && bus.addr == 8'h18 ##1 bus.rd && bus.addr == 8'h18
    |=> (rdata & 8'hE1) == ($past(bus.wdata, 2) & 8'h21))
    else $error("control readback wrong");
  AST_SPD: assert property (
    bus.wr && bus.addr == 8'h1B ##1 bus.rd && bus.addr == 8'h1B |=> rdata == $past(bus.wdata, 2))
    else $error("speed readback wrong");
  AST_OWNLO: assert property (
    bus.wr && bus.addr == 8'h1C ##1 bus.rd && bus.addr == 8'h1C |=> rdata == $past(bus.wdata, 2))
    else $error("own address low readback wrong");
  AST_OWNHI: assert property (
    bus.wr && bus.addr == 8'h1D ##1 bus.rd && bus.addr == 8'h1D |=> rdata == ($past(bus.wdata, 2) & 8'hC6))
    else $error("own address high readback wrong");
  AST_PE_OFF: assert property (
    bus.wr && bus.addr == 8'h18 && !bus.wdata[5] |=> line_oe_b == 2'b11)
    else $error("lines not released when disabled");
  AST_SR_CLR: assert property (
    bus.wr && bus.addr == 8'h18 && !bus.wdata[5] ##1 bus.rd && bus.addr == 8'h19 |=> rdata == 8'h00)
    else $error("status not cleared when disabled");
endmodule
bind icdar_core icdar_core_monitor u_icdar_core_monitor (
  .sys_clk   (sys_clk),
  .rst_b     (rst_b),
  .bus       (bus),
  .rdata     (rdata),
  .line_oe_b (line_oe_b)
);

// ---- icdar_peer.sv ----
// Purpose: Far-side party on the two-wire bus
// Assumes: Bench resolves the lines with pull-ups
// Notes:   Master toward a slave device, receiver toward a master
`timescale 1ns/100ps
module icdar_peer (
  // Clock
  input  wire logic                   sys_clk,
  // Bus lines
  input  wire icdar_pkg::icdar_line_s line,
  output icdar_pkg::icdar_line_s      oe_b
);
  import icdar_pkg::*;
  localparam int PHASE = 10;
  int unsigned cnt = 0;
  int unsigned per = 0;
  initial oe_b = '1;
  always @(posedge sys_clk) cnt <= cnt + 1;
  task gap();
    repeat (PHASE) @(posedge sys_clk);
  endtask
  // Bounded at 4000 cycles, so a device stretching the clock holds us here no longer than that
  task wait_lvl(input logic v);
    for (int i = 0; i < 4000 && line.scl !== v; i++) @(posedge sys_clk);
  endtask
  task bit_io(input logic b, output logic s);
    oe_b.sda <= b;
    gap();
    oe_b.scl <= 1'b1;
    wait_lvl(1'b1);
    gap();
    s = line.sda;
    oe_b.scl <= 1'b0;
    gap();
  endtask
  task start();
    oe_b.sda <= 1'b0;
    gap();
    oe_b.scl <= 1'b0;
    gap();
  endtask
  task stop();
    oe_b.sda <= 1'b0;
    gap();
    oe_b.scl <= 1'b1;
    wait_lvl(1'b1);
    gap();
    oe_b.sda <= 1'b1;
    gap();
  endtask
  task put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask
  // Receiver: samples at clock rise, acks, times one clock period
  task listen(output logic [7:0] b);
    int unsigned t;
    t = 0;
    for (int i = 7; i >= 0; i--) begin
      wait_lvl(1'b1);
      b[i] = line.sda;
      if (i == 6)
        per = cnt - t;
      t = cnt;
      wait_lvl(1'b0);
    end
    oe_b.sda <= 1'b0;
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    oe_b.sda <= 1'b1;
  endtask
endmodule

// ---- icdar_core_bench.sv ----
// Purpose: Self-checking bench for the two-wire bus interface core
// Assumes: Peer model on the lines, pull-ups resolved here
// Notes:   Seeded random data among hand-picked cases
`timescale 1ns/100ps
module icdar_core_bench;
  import icdar_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  icdar_bus_s  bus;
  logic [7:0]  rdata;
  icdar_line_s line_w;
  icdar_line_s dut_oe_b;
  icdar_line_s dut_o;
  icdar_line_s peer_oe_b;
  logic        irq;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  assign line_w.scl = dut_oe_b.scl & peer_oe_b.scl;
  assign line_w.sda = dut_oe_b.sda & peer_oe_b.sda;
  icdar_core u_icdar_core (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .bus       (bus),
    .rdata     (rdata),
    .line_i    (line_w),
    .line_o    (dut_o),
    .line_oe_b (dut_oe_b),
    .irq       (irq)
  );
  icdar_peer u_icdar_peer (
    .sys_clk (sys_clk),
    .line    (line_w),
    .oe_b    (peer_oe_b)
  );
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task conclude();
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] oah(input logic [7:0] d);
    return d & 8'hC6;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 q = rdata;
    @(posedge sys_clk);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    check(q, e);
  endtask
  // Write then read with no gap between the strobes
  task wrc(input logic [7:0] wa, input logic [7:0] d, input logic [7:0] ra, input logic [7:0] e);
    bus <= '{wa, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    rdc(ra, e);
  endtask
  task wait_stretch();
    int n;
    n = 0;
    for (int i = 0; i < 5000 && n < 40; i++) begin
      @(negedge sys_clk);
      n = (dut_oe_b.scl === 1'b0) ? n + 1 : 0;
    end
    @(posedge sys_clk);
  endtask
  initial begin
    logic [7:0] d, q, b0, b1, own, got;
    logic ack;
    int unsigned per[2];
    void'($urandom(32));
    rst_b = 1'b0;
    bus = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int a = 8'h18; a <= 8'h20; a++) rdc(8'(a), (a == 8'h1D) ? 8'h40 : 8'h00);
    rdc(8'h21, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wrc(OFS_OWN_HIGH, d, OFS_OWN_HIGH, oah(d));
      d = 8'($urandom);
      wrc(OFS_SPEED, d, OFS_SPEED, d);
      d = 8'($urandom);
      wrc(OFS_OWN_LOW, d, OFS_OWN_LOW, d);
      wrc(OFS_STATUS_TWO, d, OFS_STATUS_TWO, 8'h00);
      d = 8'($urandom) & 8'hE1;
      wrc(OFS_CONTROL, d, OFS_CONTROL, d & 8'h21);
      wr(OFS_CONTROL, 8'h00);
    end
    // Slave receive; own address bit 0 set but sent clear
    own = 8'((($urandom % 112) + 8) << 1) | 8'h01;
    d = 8'($urandom) & 8'h06;
    wr(OFS_OWN_HIGH, 8'h40 | d);
    wr(OFS_SPEED, 8'h84);
    wr(OFS_OWN_LOW, own);
    wr(OFS_CONTROL, 8'h25);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    fork
      begin
        u_icdar_peer.start();
        u_icdar_peer.put(own & 8'hFE, ack);
        check({7'h00, ack}, 8'h00);
        u_icdar_peer.put(b0, ack);
        u_icdar_peer.put(b1, ack);
        check({7'h00, ack}, 8'h00);
        u_icdar_peer.stop();
      end
      begin
        wait_stretch();
        rdc(OFS_BYTE, b0);
      end
    join
    rdc(OFS_BYTE, b1);
    check({7'h00, irq}, 8'h00);
    wr(OFS_EV_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(OFS_EV_FLAGS, 8'h3F);
    check({7'h00, irq}, 8'h00);
    rdc(OFS_EV_FLAGS, 8'h00);
    wrc(OFS_CONTROL, 8'h04, OFS_STATUS_ONE, 8'h00);
    rdc(OFS_STATUS_TWO, 8'h00);
    rdc(OFS_SPEED, 8'h84);
    rdc(OFS_OWN_LOW, own);
    rdc(OFS_OWN_HIGH, 8'h40 | d);
    wr(OFS_OWN_LOW, OWN_LOW_INVALID);
    wr(OFS_CONTROL, 8'h24);
    u_icdar_peer.start();
    u_icdar_peer.put(OWN_LOW_INVALID, ack);
    check({7'h00, ack}, 8'h01);
    u_icdar_peer.stop();
    // Ten-bit address: header with the two high bits, then the low byte
    wr(OFS_OWN_LOW, own);
    u_icdar_peer.start();
    u_icdar_peer.put({TEN_HEADER, d[2:1], 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    u_icdar_peer.put(own, ack);
    check({7'h00, ack}, 8'h00);
    u_icdar_peer.stop();
    // Master transmit in fast then standard timing
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_SPEED, (m == 1) ? 8'h04 : 8'h84);
      wr(OFS_CONTROL, 8'h2C);
      q = 8'h00;
      for (int i = 0; i < 40 && q[0] !== 1'b1; i++) rd(OFS_STATUS_ONE, q);
      d = 8'($urandom);
      fork
        u_icdar_peer.listen(got);
        wr(OFS_BYTE, d);
      join
      check(got, d);
      per[m] = u_icdar_peer.per;
      wr(OFS_CONTROL, 8'h26);
      for (int i = 0; i < 200 && dut_oe_b !== 2'b11; i++) @(posedge sys_clk);
      check({6'h00, dut_oe_b}, 8'h03);
    end
    check({6'h00, dut_o}, 8'h00);
    check({7'h00, per[1] > per[0]}, 8'h01);
    conclude();
  end
endmodule
